// [src/tss_defs.svh]
// Purpose: constants for the tension setpoint selector
// Assumes: byte addressed register port, 32-bit words
// Notes: data sets sit in a window of 64 words
// Functional notes
// - The three select inputs form a binary set number, bit 2 most significant.
// - With analog enabled, set 0 uses the internal pot, set 1 the external voltage.
// - With analog disabled, all eight sets use stored digital values.
// - A changed system parameter takes effect only at the next power-up; here only analog enable waits, auto offset, gain and offset act at once.
// - The internal pot gives 0 to 100 percent, default 0 percent.
// - External voltage is scaled by a gain of 0 to 100 percent per volt, default 10.
// - The offset voltage is subtracted before the gain is applied.
// - With auto offset on, a capture request stores the measured input as offset.
// - With auto offset off, the offset parameter is used, not a captured value.
// - The sixteen dial positions map to minimum speeds from 10 to 3000 r/min.
// - Motor speed varies inversely with torque, tracking the tension command.
// - Each set holds eight values with initial 0,0,50,500,1000,100,0,0.
`ifndef TSS_DEFS_SVH
`define TSS_DEFS_SVH
`define TSS_ADDR_W      10
`define TSS_OFS_CTRL    10'h000
`define TSS_OFS_GAIN    10'h004
`define TSS_OFS_OFFSET  10'h008
`define TSS_OFS_CMD     10'h00C
`define TSS_OFS_STATUS  10'h010
`define TSS_OFS_TENSION 10'h014
`define TSS_OFS_MINSPD  10'h018
`define TSS_OFS_CAPT    10'h01C
`define TSS_OFS_SPDREF  10'h020
`define TSS_OFS_SETS    10'h100
`define TSS_CTRL_ANA    0
`define TSS_CTRL_AUTO   1
`define TSS_CMD_CAPT    0
`define TSS_RST_ANA     1'h1
`define TSS_RST_AUTO    1'h0
`define TSS_RST_GAIN    7'h0A
`define TSS_RST_OFFSET  16'h0000
`define TSS_PCT_MAX     7'h64
`define TSS_MV_PER_V    1000
`define TSS_INIT_SPDLIM 16'h0000
`define TSS_INIT_TENS   16'h0000
`define TSS_INIT_THICK  16'h0032
`define TSS_INIT_DINIT  16'h01F4
`define TSS_INIT_DFIN   16'h03E8
`define TSS_INIT_TAPER  16'h0064
`define TSS_INIT_JMAT   16'h0000
`define TSS_INIT_JCORE  16'h0000
`define TSS_MS0 12'h00A
`define TSS_MS1 12'h00F
`define TSS_MS2 12'h016
`define TSS_MS3 12'h021
`define TSS_MS4 12'h02F
`define TSS_MS5 12'h044
`define TSS_MS6 12'h064
`define TSS_MS7 12'h096
`define TSS_MS8 12'h0DC
`define TSS_MS9 12'h14A
`define TSS_MSA 12'h1D6
`define TSS_MSB 12'h2A8
`define TSS_MSC 12'h3E8
`define TSS_MSD 12'h5DC
`define TSS_MSE 12'h898
`define TSS_MSF 12'hBB8
`endif

// [src/tss_pkg.sv]
// Purpose: types for the tension setpoint selector
// Assumes: tss_defs.svh constants
// Notes: none
package tss_pkg;
    typedef enum logic [1:0] {
        SRC_DIGITAL = 2'b00,
        SRC_POT     = 2'b01,
        SRC_EXT     = 2'b10
    } tss_src_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [9:0]  addr;
        logic [31:0] wdata;
    } tss_req_t;

    typedef struct packed {
        logic [2:0]  activeSet;
        tss_src_t    source;
        logic [6:0]  tensionPct;
        logic [11:0] minSpeed;
        logic [18:0] speedRef;
    } tss_cmd_t;
endpackage

// [src/tss_selector.sv]
// Purpose: picks and scales the tension setpoint in simple mode
// Assumes: all inputs synchronous to clk; powerUp marks supply return
// Notes: only analog enable held pending until powerUp; auto offset, gain and offset act at once
`timescale 1ns/1ps
`include "tss_defs.svh"
module tss_selector #(
    parameter int DATA_W = 16
) (
    input  wire logic            clk,
    input  wire logic            nrst,
    input  wire logic            powerUp,
    input  wire logic            set_select_bit0,
    input  wire logic            set_select_bit1,
    input  wire logic            set_select_bit2,
    input  wire logic [6:0]      internal_setpoint_pot,
    input  wire logic [15:0]     extVoltMv,
    input  wire logic [3:0]      min_speed_dial,
    input  wire logic [6:0]      torquePct,
    input  wire tss_pkg::tss_req_t regReq,
    output logic [31:0]          rdata,
    output tss_pkg::tss_cmd_t    cmdOut,
    output logic [DATA_W-1:0]    speedLimit
);
    // Set fields are cut from the 32-bit write word
    if (DATA_W < 12 || DATA_W > 32)
    begin
        $error("DATA_W must be 12 to 32");
    end

    logic [DATA_W-1:0] setMem [64];
    logic        anaPend_q;
    logic        anaAct_q;
    logic        autoEn_q;
    logic [6:0]  gain_q;
    logic [15:0] offset_q;
    logic [15:0] capt_q;
    logic [31:0] rdata_q;
    logic [2:0]  set_q;
    tss_pkg::tss_src_t src_q;
    logic [6:0]  tens_q;
    logic [11:0] minSpd_q;
    logic [18:0] spdRef_q;
    logic [DATA_W-1:0] spdLim_q;

    wire [2:0] selSet = {set_select_bit2, set_select_bit1, set_select_bit0};

    wire wrCtrl   = regReq.wr && regReq.addr == `TSS_OFS_CTRL;
    wire wrGain   = regReq.wr && regReq.addr == `TSS_OFS_GAIN;
    wire wrOffset = regReq.wr && regReq.addr == `TSS_OFS_OFFSET;
    wire wrCmd    = regReq.wr && regReq.addr == `TSS_OFS_CMD;
    wire inSets   = regReq.addr[9:8] == 2'(`TSS_OFS_SETS >> 8) && regReq.addr[1:0] == 2'h0;
    wire wrSet    = regReq.wr && inSets;
    wire [5:0] setIdx = regReq.addr[7:2];

    // capture only while auto offset on
    wire captReq = wrCmd && regReq.wdata[`TSS_CMD_CAPT] && autoEn_q;

    wire [6:0] gainIn = regReq.wdata[6:0] > `TSS_PCT_MAX
                        || regReq.wdata[31:7] != 25'h0 ? `TSS_PCT_MAX : regReq.wdata[6:0];

    // offset source, parameter when auto off
    wire signed [15:0] offUse = autoEn_q ? $signed(capt_q) : $signed(offset_q);
    wire signed [16:0] diffMv = 17'($signed(extVoltMv)) - 17'(offUse);
    wire signed [24:0] prodMv = 25'(diffMv) * 25'($signed({1'b0, gain_q}));
    wire signed [24:0] rawPct = prodMv / 25'(`TSS_MV_PER_V);
    wire [6:0] extPct = rawPct < 25'sd0 ? 7'h00
                      : rawPct > 25'($signed({18'h0, `TSS_PCT_MAX})) ? `TSS_PCT_MAX
                      : rawPct[6:0];
    wire [6:0] potPct = internal_setpoint_pot > `TSS_PCT_MAX ? `TSS_PCT_MAX
                                                              : internal_setpoint_pot;

    // field 0 speed limit, field 1 tension
    wire [DATA_W-1:0] digTens = setMem[{selSet, 3'h1}];
    wire [DATA_W-1:0] digLim  = setMem[{selSet, 3'h0}];
    wire [6:0] digPct = digTens > DATA_W'(`TSS_PCT_MAX) ? `TSS_PCT_MAX : digTens[6:0];

    // analog for sets 0 and 1, sets 2 to 7 digital
    wire useAna = anaAct_q && selSet[2:1] == 2'h0;
    tss_pkg::tss_src_t srcSel;
    assign srcSel = !useAna ? tss_pkg::SRC_DIGITAL
                  : selSet[0] ? tss_pkg::SRC_EXT : tss_pkg::SRC_POT;
    wire [6:0] tensSel = srcSel == tss_pkg::SRC_POT ? potPct
                       : srcSel == tss_pkg::SRC_EXT ? extPct : digPct;

    logic [11:0] dialSpd;
    always_comb
    begin
        unique case (min_speed_dial)
            4'h0: dialSpd = `TSS_MS0;
            4'h1: dialSpd = `TSS_MS1;
            4'h2: dialSpd = `TSS_MS2;
            4'h3: dialSpd = `TSS_MS3;
            4'h4: dialSpd = `TSS_MS4;
            4'h5: dialSpd = `TSS_MS5;
            4'h6: dialSpd = `TSS_MS6;
            4'h7: dialSpd = `TSS_MS7;
            4'h8: dialSpd = `TSS_MS8;
            4'h9: dialSpd = `TSS_MS9;
            4'hA: dialSpd = `TSS_MSA;
            4'hB: dialSpd = `TSS_MSB;
            4'hC: dialSpd = `TSS_MSC;
            4'hD: dialSpd = `TSS_MSD;
            4'hE: dialSpd = `TSS_MSE;
            4'hF: dialSpd = `TSS_MSF;
        endcase
    end

    // speed inverse to torque, torque 0 read as 1
    wire [6:0]  torqDiv = torquePct == 7'h00 ? 7'h01 : torquePct;
    wire [18:0] spdProd = 19'(tens_q) * 19'(minSpd_q);
    wire [18:0] spdRaw  = spdProd / 19'(torqDiv);
    wire        limOn   = spdLim_q != '0;
    wire [18:0] spdNext = limOn && 32'(spdRaw) > 32'(spdLim_q)
                          ? 19'(spdLim_q) : spdRaw;

    logic [31:0] rdMux;
    always_comb
    begin
        rdMux = 32'h0;
        if (inSets)
            rdMux = 32'(setMem[setIdx]);
        else
        begin
            unique case (regReq.addr)
                `TSS_OFS_CTRL:    rdMux = {30'h0, autoEn_q, anaPend_q};
                `TSS_OFS_GAIN:    rdMux = {25'h0, gain_q};
                `TSS_OFS_OFFSET:  rdMux = {16'h0, offset_q};
                `TSS_OFS_STATUS:  rdMux = {26'h0, anaAct_q, src_q, set_q};
                `TSS_OFS_TENSION: rdMux = {25'h0, tens_q};
                `TSS_OFS_MINSPD:  rdMux = {20'h0, minSpd_q};
                `TSS_OFS_CAPT:    rdMux = {16'h0, capt_q};
                `TSS_OFS_SPDREF:  rdMux = {13'h0, spdRef_q};
                default:          rdMux = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            anaPend_q <= `TSS_RST_ANA;
            anaAct_q  <= `TSS_RST_ANA;
        end
        else
        begin
            if (wrCtrl)
                anaPend_q <= regReq.wdata[`TSS_CTRL_ANA];
            if (powerUp)
                anaAct_q <= wrCtrl ? regReq.wdata[`TSS_CTRL_ANA] : anaPend_q;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            autoEn_q <= `TSS_RST_AUTO;
            gain_q   <= `TSS_RST_GAIN;
            offset_q <= `TSS_RST_OFFSET;
            capt_q   <= `TSS_RST_OFFSET;
        end
        else
        begin
            if (wrCtrl)
                autoEn_q <= regReq.wdata[`TSS_CTRL_AUTO];
            if (wrGain)
                gain_q <= gainIn;
            if (wrOffset)
                offset_q <= regReq.wdata[15:0];
            if (captReq)
                capt_q <= extVoltMv;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int s = 0; s < 8; s++)
            begin
                setMem[s*8+0] <= DATA_W'(`TSS_INIT_SPDLIM);
                setMem[s*8+1] <= DATA_W'(`TSS_INIT_TENS);
                setMem[s*8+2] <= DATA_W'(`TSS_INIT_THICK);
                setMem[s*8+3] <= DATA_W'(`TSS_INIT_DINIT);
                setMem[s*8+4] <= DATA_W'(`TSS_INIT_DFIN);
                setMem[s*8+5] <= DATA_W'(`TSS_INIT_TAPER);
                setMem[s*8+6] <= DATA_W'(`TSS_INIT_JMAT);
                setMem[s*8+7] <= DATA_W'(`TSS_INIT_JCORE);
            end
        end
        else if (wrSet)
            setMem[setIdx] <= regReq.wdata[DATA_W-1:0];
    end

    // Outputs registered; speed uses previous tension, one cycle lag
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_q  <= 32'h0;
            set_q    <= 3'h0;
            src_q    <= tss_pkg::SRC_DIGITAL;
            tens_q   <= 7'h00;
            minSpd_q <= `TSS_MS0;
            spdRef_q <= 19'h0;
            spdLim_q <= '0;
        end
        else
        begin
            rdata_q  <= regReq.rd ? rdMux : 32'h0;
            set_q    <= selSet;
            src_q    <= srcSel;
            tens_q   <= tensSel;
            minSpd_q <= dialSpd;
            spdRef_q <= spdNext;
            spdLim_q <= digLim;
        end
    end

    assign rdata      = rdata_q;
    assign speedLimit = spdLim_q;
    assign cmdOut     = '{activeSet:  set_q,
                          source:     src_q,
                          tensionPct: tens_q,
                          minSpeed:   minSpd_q,
                          speedRef:   spdRef_q};
endmodule

// [verif/tss_host_model.sv]
// Purpose: host driving set select pins and dial
// Assumes: set number and dial chosen by the bench
// Notes: plain wiring, no timing of its own
`timescale 1ns/1ps
module tss_host_model (
    input  wire logic [2:0] setNum,
    input  wire logic [3:0] dialPos,
    output logic [2:0]      selPins,
    output logic [3:0]      min_speed_dial
);
    assign selPins = setNum;
    assign min_speed_dial = dialPos;
endmodule

// [verif/tss_selector_assertions.sv]
// Purpose: port checks for tss_selector
// Assumes: one clock, nrst async low
// Notes: bound below the module
`timescale 1ns/1ps
module tss_selector_assertions (
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic              powerUp,
    input wire logic              set_select_bit0,
    input wire logic              set_select_bit1,
    input wire logic              set_select_bit2,
    input wire logic [6:0]        internal_setpoint_pot,
    input wire logic [3:0]        min_speed_dial,
    input wire tss_pkg::tss_req_t regReq,
    input wire tss_pkg::tss_cmd_t cmdOut
);
    localparam logic [11:0] MS_TAB [16] = '{12'h00A, 12'h00F, 12'h016, 12'h021, 12'h02F,
        12'h044, 12'h064, 12'h096, 12'h0DC, 12'h14A, 12'h1D6, 12'h2A8, 12'h3E8, 12'h5DC,
        12'h898, 12'hBB8};
    logic [2:0] selNow;
    assign selNow = {set_select_bit2, set_select_bit1, set_select_bit0};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    property p_set_code; $past(nrst) |-> cmdOut.activeSet == $past(selNow); endproperty
    a_set_code: assert property (p_set_code) else $error("set number wrong");
    property p_upper_digital; $past(selNow) >= 3'h2 |-> cmdOut.source == tss_pkg::SRC_DIGITAL;
    endproperty
    a_upper_digital: assert property (p_upper_digital) else $error("upper set not digital");
    property p_analog_slot; cmdOut.source == tss_pkg::SRC_POT |-> cmdOut.activeSet == 3'h0;
    endproperty
    a_analog_slot: assert property (p_analog_slot) else $error("pot used off set 0");
    property p_pot_follow; cmdOut.source == tss_pkg::SRC_POT |-> cmdOut.tensionPct ==
        (($past(internal_setpoint_pot) > 7'h64) ? 7'h64 : $past(internal_setpoint_pot));
    endproperty
    a_pot_follow: assert property (p_pot_follow) else $error("pot tension wrong");
    property p_cmd_range; cmdOut.tensionPct <= 7'h64; endproperty
    a_cmd_range: assert property (p_cmd_range) else $error("tension above full");
    property p_dial_map; $past(nrst) |-> cmdOut.minSpeed == MS_TAB[$past(min_speed_dial)];
    endproperty
    a_dial_map: assert property (p_dial_map) else $error("minimum speed wrong");
    // Reset edge and power-up edges are excluded
    property p_hold_param; $past(nrst) && !$past(powerUp) && !$past(powerUp, 2) &&
        $past(nrst, 2) && $past(selNow) == 3'h1 && $past(selNow, 2) == 3'h1 |->
        $stable(cmdOut.source);
    endproperty
    a_hold_param: assert property (p_hold_param) else $error("source moved early");
    property p_zero_ref; $past(cmdOut.tensionPct) == 7'h00 |-> cmdOut.speedRef == 19'h00000;
    endproperty
    a_zero_ref: assert property (p_zero_ref) else $error("speed with no tension");
    c_pot: cover property (cmdOut.source == tss_pkg::SRC_POT);
    c_ext: cover property (cmdOut.source == tss_pkg::SRC_EXT);
    c_capture: cover property (regReq.wr && regReq.addr == 10'h00C);
endmodule
bind tss_selector tss_selector_assertions chk (.clk(clk), .nrst(nrst), .powerUp(powerUp),
    .set_select_bit0(set_select_bit0), .set_select_bit1(set_select_bit1),
    .set_select_bit2(set_select_bit2), .internal_setpoint_pot(internal_setpoint_pot),
    .min_speed_dial(min_speed_dial), .regReq(regReq), .cmdOut(cmdOut));

// [verif/tss_selector_tb.sv]
// Purpose: self-checking bench for tss_selector
// Assumes: torque held steady within each check
// Notes: reset reads and set writes first, then table rows, register cases after
`timescale 1ns/1ps
module tss_selector_tb;
    logic              clk = 1'b0;
    logic              nrst = 1'b0;
    logic              powerUp = 1'b0;
    logic [2:0]        selNum = '0;
    logic [3:0]        dial = '0;
    logic [6:0]        pot = '0;
    logic [15:0]       volt = '0;
    // feed steady, torque held per check
    logic [6:0]        torq = 7'h32;
    logic [2:0]        sb;
    logic [3:0]        dialPin;
    logic [31:0]       rdata;
    logic [15:0]       spdLim;
    tss_pkg::tss_req_t req = '0;
    tss_pkg::tss_cmd_t cmd;
    int                failCount = 0;
    int                nChecks = 0;
    logic [11:0]       ms [16] = '{12'h00A, 12'h00F, 12'h016, 12'h021, 12'h02F, 12'h044,
        12'h064, 12'h096, 12'h0DC, 12'h14A, 12'h1D6, 12'h2A8, 12'h3E8, 12'h5DC, 12'h898, 12'hBB8};
    logic [15:0]       initVal [8] = '{16'h0000, 16'h0000, 16'h0032, 16'h01F4, 16'h03E8,
        16'h0064, 16'h0000, 16'h0000};
    // Row: set, pot, volt mV, source, tension
    logic [34:0]       rows [16] = '{
        {3'h0, 7'h25, 16'h0000, 2'h1, 7'h25}, {3'h1, 7'h00, 16'h1388, 2'h2, 7'h32},
        {3'h2, 7'h00, 16'h0000, 2'h0, 7'h19}, {3'h3, 7'h00, 16'h0000, 2'h0, 7'h24},
        {3'h4, 7'h00, 16'h0000, 2'h0, 7'h2F}, {3'h5, 7'h00, 16'h0000, 2'h0, 7'h3A},
        {3'h6, 7'h00, 16'h0000, 2'h0, 7'h45}, {3'h7, 7'h00, 16'h0000, 2'h0, 7'h50},
        {3'h0, 7'h64, 16'h0000, 2'h1, 7'h64}, {3'h1, 7'h00, 16'h2EE0, 2'h2, 7'h64},
        {3'h1, 7'h00, 16'hF448, 2'h2, 7'h00}, {3'h1, 7'h00, 16'h270F, 2'h2, 7'h63},
        {3'h0, 7'h00, 16'h0000, 2'h1, 7'h00}, {3'h0, 7'h78, 16'h0000, 2'h1, 7'h64},
        {3'h7, 7'h00, 16'h0000, 2'h0, 7'h50}, {3'h1, 7'h00, 16'h03E8, 2'h2, 7'h0A}};
    tss_host_model host (.setNum(selNum), .dialPos(dial), .selPins(sb), .min_speed_dial(dialPin));
    tss_selector uut (.clk(clk), .nrst(nrst), .powerUp(powerUp), .set_select_bit0(sb[0]),
        .set_select_bit1(sb[1]), .set_select_bit2(sb[2]), .internal_setpoint_pot(pot),
        .extVoltMv(volt), .min_speed_dial(dialPin), .torquePct(torq), .regReq(req),
        .rdata(rdata), .cmdOut(cmd), .speedLimit(spdLim));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            failCount++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 32'h00000000};
        @(posedge clk);
        req <= '0;
        #1;
        chk("rdata", rdata, e);
    endtask
    // Speed reference lands one cycle after tension
    task automatic go(input logic [34:0] r, input logic [3:0] d);
        int e;
        @(posedge clk);
        selNum <= r[34:32];
        pot <= r[31:25];
        volt <= r[24:9];
        dial <= d;
        repeat (3) @(posedge clk);
        #1;
        e = r[6:0] * ms[d] / (torq == 7'h00 ? 7'h01 : torq);
        if (r[34:32] == 3'h7 && e > 100) e = 100;
        chk("set", cmd.activeSet, r[34:32]);
        chk("source", cmd.source, r[8:7]);
        chk("tension", cmd.tensionPct, r[6:0]);
        chk("minSpeed", cmd.minSpeed, ms[d]);
        chk("speedRef", cmd.speedRef, e);
        chk("speedLimit", spdLim, r[34:32] == 3'h7 ? 32'h00000064 : 32'h00000000);
    endtask
    task finalReport;
        if (failCount == 0 && nChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
        forever #2.5 clk = ~clk;
    initial
    begin
        #50000;
        failCount++;
        finalReport;
    end
    initial
    begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 64; i++)
            rd(10'(12'h100 + i * 4), {16'h0000, initVal[i % 8]});
        rd(10'h004, 32'h0000000A);
        rd(10'h000, 32'h00000001);
        for (int k = 0; k < 8; k++)
            wr(10'(12'h104 + k * 32), 32'(11 * k + 3));
        wr(10'h1E0, 32'h00000064);
        for (int i = 0; i < 16; i++)
            go(rows[i], 4'(i));
        wr(10'h008, 32'h000003E8);
        go({3'h1, 7'h00, 16'h0BB8, 2'h2, 7'h14}, 4'h2);
        // Input held near zero while capturing
        wr(10'h000, 32'h00000003);
        go({3'h1, 7'h00, 16'h00FA, 2'h2, 7'h02}, 4'h2);
        wr(10'h00C, 32'h00000001);
        rd(10'h01C, 32'h000000FA);
        go({3'h1, 7'h00, 16'h1482, 2'h2, 7'h32}, 4'h2);
        wr(10'h000, 32'h00000001);
        go({3'h1, 7'h00, 16'h1482, 2'h2, 7'h2A}, 4'h2);
        wr(10'h004, 32'h00000078);
        rd(10'h004, 32'h00000064);
        rd(10'h3FC, 32'h00000000);
        go({3'h1, 7'h00, 16'h1482, 2'h2, 7'h64}, 4'h2);
        wr(10'h000, 32'h00000000);
        go({3'h1, 7'h00, 16'h1482, 2'h2, 7'h64}, 4'h2);
        @(posedge clk);
        powerUp <= 1'b1;
        @(posedge clk);
        powerUp <= 1'b0;
        go({3'h0, 7'h25, 16'h1482, 2'h0, 7'h03}, 4'h2);
        go({3'h1, 7'h25, 16'h1482, 2'h0, 7'h0E}, 4'h2);
        rd(10'h000, 32'h00000000);
        rd(10'h008, 32'h000003E8);
        rd(10'h010, 32'h00000001);
        rd(10'h014, 32'h0000000E);
        rd(10'h018, 32'h00000016);
        rd(10'h020, 32'h00000006);
        // Torque steps, zero torque read as one
        @(posedge clk);
        torq <= 7'h07;
        go({3'h1, 7'h00, 16'h1482, 2'h0, 7'h0E}, 4'hF);
        @(posedge clk);
        torq <= 7'h00;
        go({3'h1, 7'h00, 16'h1482, 2'h0, 7'h0E}, 4'hF);
        // Mid-run reset with set 1 still selected
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        #1;
        chk("rstSet", cmd.activeSet, 32'h0);
        chk("rstSource", cmd.source, 32'h0);
        chk("rstTension", cmd.tensionPct, 32'h0);
        chk("rstMinSpeed", cmd.minSpeed, 32'h0000000A);
        chk("rstSpeedRef", cmd.speedRef, 32'h0);
        chk("rstSpeedLimit", spdLim, 32'h0);
        chk("rstRdata", rdata, 32'h0);
        @(posedge clk);
        nrst <= 1'b1;
        rd(10'h000, 32'h00000001);
        rd(10'h004, 32'h0000000A);
        rd(10'h1E0, 32'h00000000);
        go({3'h1, 7'h00, 16'h1482, 2'h2, 7'h34}, 4'hF);
        finalReport;
    end
endmodule
